/* File: hdl/egress_pacer.sv */
// One queue's per-byte pacing timer
`timescale 1ns/1ns
`default_nettype none
module egress_pacer
  import pacing_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [RATE_W-1:0] rate,
  input wire logic enable,
  input wire logic tick,
  input wire logic byte_req,
  output logic byte_grant,
  output logic busy
);

  logic [RATE_W-1:0] wait_ff;
  logic [RATE_W-1:0] nxt_wait;

  // While enabled, grant only once the previous byte's time has run out; with enable low, grant every request at once
  // hold next byte
  assign busy = (wait_ff != RATE_RESET);
  assign byte_grant = byte_req & (~enable | ~busy);

  // Load the step count on a grant, then count steps down
  always_comb
  begin
    nxt_wait = wait_ff;
    if (!enable)
    begin
      nxt_wait = RATE_RESET;
    end
    else if (byte_grant)
    begin
      nxt_wait = rate;
    end
    else if (tick && busy)
    begin
      nxt_wait = wait_ff - 13'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wait_ff <= RATE_RESET;
    else
      wait_ff <= nxt_wait;
  end

endmodule
`default_nettype wire

/* File: hdl/pacing_pkg.sv */
// Constants, register map and field layout of the egress pacing and default tag register bank
// What this block does
// - Per-byte transmit time equals rate field plus one, times 20 ns.
// - Rate fields mean time spent per byte, never a bit rate.
// - Port 0 rate register: queue 1 in bits 25:13, queue 0 in 12:0.
// - Port 0 second rate register at index 1C0Eh: queue 3 high, queue 2 low.
// - Port 1 rate registers: queues 0/1 at 1C0Fh, queues 2/3 at 1C10h.
// - Port 2 rate registers: queues 0/1 at 1C11h, queues 2/3 at 1C12h.
// - Rate values act only while the global pacing enable is set.
// - Port 0 default priority, bits 14:12, resets to zero, used on tag insert/change.
// - Port 0 default VLAN ID, bits 11:0, resets to one, used on tag insert/change.
// - Default VLAN ID and priority live alone in the register at index 1C13h.
// - Priority-tagged packets always get the default VLAN ID, whatever change-VID says.
package pacing_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [13:0] IDX_RATE_P0_Q01 = 14'h1C0D;
  localparam logic [13:0] IDX_RATE_P0_Q23 = 14'h1C0E;
  localparam logic [13:0] IDX_RATE_P1_Q01 = 14'h1C0F;
  localparam logic [13:0] IDX_RATE_P1_Q23 = 14'h1C10;
  localparam logic [13:0] IDX_RATE_P2_Q01 = 14'h1C11;
  localparam logic [13:0] IDX_RATE_P2_Q23 = 14'h1C12;
  localparam logic [13:0] IDX_PORT0_TAG = 14'h1C13;
  localparam logic [13:0] IDX_PACING_CTRL = 14'h1C1E;
  localparam logic [13:0] IDX_PACING_STATUS = 14'h1C1F;

  // Bus widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;

  // Topology
  localparam int NUM_PORTS = 3;
  localparam int NUM_QUEUES = 4;
  localparam int NUM_PACERS = 12;
  localparam int NUM_RATE_REGS = 6;

  // Field layout
  localparam int RATE_W = 13;
  localparam int RATE_LO_LSB = 0;
  localparam int RATE_HI_LSB = 13;
  localparam int VID_W = 12;
  localparam int VID_LSB = 0;
  localparam int PRI_W = 3;
  localparam int PRI_LSB = 12;
  localparam int PACE_EN_BIT = 0;

  // Reset values
  localparam logic [RATE_W-1:0] RATE_RESET = 13'h0000;
  localparam logic [VID_W-1:0] VID_RESET = 12'h001;
  localparam logic [PRI_W-1:0] PRI_RESET = 3'h0;
  localparam logic PACE_EN_RESET = 1'b0;

  // Timing: one rate step is 20 ns, clock period is 20 ns
  localparam int CLK_PERIOD_NS = 20;
  localparam int RATE_STEP_NS = 20;
  localparam int STEP_CYCLES_RAW = RATE_STEP_NS / CLK_PERIOD_NS;
  localparam int STEP_CYCLES = (STEP_CYCLES_RAW < 1) ? 1 : STEP_CYCLES_RAW;
  localparam int STEP_CNT_W = 4;

  // Register select produced by address decode
  typedef enum {
    SEL_RATE0,
    SEL_RATE1,
    SEL_RATE2,
    SEL_RATE3,
    SEL_RATE4,
    SEL_RATE5,
    SEL_TAG,
    SEL_CTRL,
    SEL_STAT,
    SEL_NONE
  } reg_sel_t;

endpackage

/* File: hdl/pacing_tag_regs.sv */
// APB register bank for egress pacing and port 0 default tag, with pacers and tag rewrite
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ns
`default_nettype none
module pacing_tag_regs
  import pacing_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [STRB_W-1:0] pstrb,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_PACERS-1:0] byte_req,
  output logic [NUM_PACERS-1:0] byte_grant,
  output logic [NUM_PACERS-1:0] queue_busy,
  output logic pace_active,
  input wire logic tag_valid_in,
  input wire logic tag_priority_tagged,
  input wire logic tag_insert,
  input wire logic tag_change_vid,
  input wire logic tag_change_pri,
  input wire logic [VID_W-1:0] tag_vid_in,
  input wire logic [PRI_W-1:0] tag_pri_in,
  output logic tag_valid_out,
  output logic [VID_W-1:0] tag_vid_out,
  output logic [PRI_W-1:0] tag_pri_out,
  output logic [VID_W-1:0] default_vid,
  output logic [PRI_W-1:0] default_pri
);

  // Map a byte address onto a register; misaligned or unknown gives none
  function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
    logic [13:0] idx;
    idx = addr[ADDR_W-1:2];
    decode = SEL_NONE;
    if (addr[1:0] == 2'h0)
    begin
      case (idx)
        IDX_RATE_P0_Q01: decode = SEL_RATE0;
        IDX_RATE_P0_Q23: decode = SEL_RATE1;
        IDX_RATE_P1_Q01: decode = SEL_RATE2;
        IDX_RATE_P1_Q23: decode = SEL_RATE3;
        IDX_RATE_P2_Q01: decode = SEL_RATE4;
        IDX_RATE_P2_Q23: decode = SEL_RATE5;
        IDX_PORT0_TAG: decode = SEL_TAG;
        IDX_PACING_CTRL: decode = SEL_CTRL;
        IDX_PACING_STATUS: decode = SEL_STAT;
        default: decode = SEL_NONE;
      endcase
    end
  endfunction

  // Rate register slot number for a select; only meaningful for rate selects
  function automatic int unsigned rate_slot(input reg_sel_t sel);
    rate_slot = 0;
    case (sel)
      SEL_RATE0: rate_slot = 0;
      SEL_RATE1: rate_slot = 1;
      SEL_RATE2: rate_slot = 2;
      SEL_RATE3: rate_slot = 3;
      SEL_RATE4: rate_slot = 4;
      SEL_RATE5: rate_slot = 5;
      default: rate_slot = 0;
    endcase
  endfunction

  // Byte-lane merge of write data into the current word
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_word,
                                               input logic [DATA_W-1:0] new_word,
                                               input logic [STRB_W-1:0] strb);
    merge = old_word;
    for (int b = 0; b < STRB_W; b++)
    begin
      if (strb[b])
        merge[b*8 +: 8] = new_word[b*8 +: 8];
    end
  endfunction

  // Register state
  logic [RATE_W-1:0] rate_ff [NUM_PACERS];
  logic [RATE_W-1:0] nxt_rate [NUM_PACERS];
  logic [VID_W-1:0] vid_ff;
  logic [VID_W-1:0] nxt_vid;
  logic [PRI_W-1:0] pri_ff;
  logic [PRI_W-1:0] nxt_pri;
  logic pace_en_ff;
  logic nxt_pace_en;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;
  logic err_ff;
  logic nxt_err;

  // Tag rewrite state
  logic tag_valid_ff;
  logic nxt_tag_valid;
  logic [VID_W-1:0] tag_vid_ff;
  logic [VID_W-1:0] nxt_tag_vid;
  logic [PRI_W-1:0] tag_pri_ff;
  logic [PRI_W-1:0] nxt_tag_pri;

  // Timebase state
  logic [STEP_CNT_W-1:0] step_ff;
  logic [STEP_CNT_W-1:0] nxt_step;
  logic tick;

  // Bus phase decode and the word being read or merged
  logic setup_phase;
  logic access_wr;
  reg_sel_t sel;
  logic [DATA_W-1:0] cur_word;
  logic [DATA_W-1:0] wr_word;

  // APB phases; a write lands only in the access phase
  assign setup_phase = psel & ~penable;
  assign access_wr = psel & penable & pwrite;
  assign sel = decode(paddr);

  // Current contents of the addressed register, reserved bits as zero
  always_comb
  begin
    int unsigned k;
    k = rate_slot(sel);
    cur_word = '0;
    case (sel)
      SEL_RATE0, SEL_RATE1, SEL_RATE2, SEL_RATE3, SEL_RATE4, SEL_RATE5:
      begin
        cur_word[RATE_LO_LSB +: RATE_W] = rate_ff[2*k];
        cur_word[RATE_HI_LSB +: RATE_W] = rate_ff[2*k+1];
      end
      SEL_TAG:
      begin
        cur_word[VID_LSB +: VID_W] = vid_ff;
        cur_word[PRI_LSB +: PRI_W] = pri_ff;
      end
      SEL_CTRL:
      begin
        cur_word[PACE_EN_BIT] = pace_en_ff;
      end
      SEL_STAT:
      begin
        // Live busy flags; a read may race a queue finishing its byte
        cur_word[NUM_PACERS-1:0] = queue_busy;
      end
      default:
      begin
        cur_word = '0;
      end
    endcase
  end

  assign wr_word = merge(cur_word, pwdata, pstrb);

  // Next register values; writes land in the access phase, which never waits
  always_comb
  begin
    int unsigned k;
    k = rate_slot(sel);
    for (int i = 0; i < NUM_PACERS; i++)
    begin
      nxt_rate[i] = rate_ff[i];
    end
    nxt_vid = vid_ff;
    nxt_pri = pri_ff;
    nxt_pace_en = pace_en_ff;
    if (access_wr)
    begin
      case (sel)
        SEL_RATE0, SEL_RATE1, SEL_RATE2, SEL_RATE3, SEL_RATE4, SEL_RATE5:
        begin
          // low field even queue, high field odd queue
          nxt_rate[2*k] = wr_word[RATE_LO_LSB +: RATE_W];
          nxt_rate[2*k+1] = wr_word[RATE_HI_LSB +: RATE_W];
        end
        SEL_TAG:
        begin
          nxt_vid = wr_word[VID_LSB +: VID_W];
          nxt_pri = wr_word[PRI_LSB +: PRI_W];
        end
        SEL_CTRL:
        begin
          nxt_pace_en = wr_word[PACE_EN_BIT];
        end
        default:
        begin
          // Status and unmapped writes are dropped without side effects
          nxt_pace_en = pace_en_ff;
        end
      endcase
    end
  end

  // Read data and error are captured in the setup phase so they come from flops
  always_comb
  begin
    nxt_rdata = rdata_ff;
    nxt_err = err_ff;
    if (setup_phase)
    begin
      // Write cycles return zero so stale read data never leaks
      nxt_rdata = pwrite ? '0 : cur_word;
      nxt_err = (sel == SEL_NONE);
    end
  end

  // Register file; reset values come from the package
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NUM_PACERS; i++)
      begin
        rate_ff[i] <= RATE_RESET;
      end
      vid_ff <= VID_RESET;
      pri_ff <= PRI_RESET;
      pace_en_ff <= PACE_EN_RESET;
      rdata_ff <= '0;
      err_ff <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < NUM_PACERS; i++)
      begin
        rate_ff[i] <= nxt_rate[i];
      end
      vid_ff <= nxt_vid;
      pri_ff <= nxt_pri;
      pace_en_ff <= nxt_pace_en;
      rdata_ff <= nxt_rdata;
      err_ff <= nxt_err;
    end
  end

  // Zero-wait slave: every access phase completes at once
  // A slower core bus would need pready from a wait counter instead
  assign pready = 1'b1;
  assign prdata = rdata_ff;
  assign pslverr = psel & penable & err_ff;

  // Timebase: one tick per rate step, held in reset while pacing is off
  always_comb
  begin
    nxt_step = step_ff;
    if (!pace_en_ff || tick)
      nxt_step = '0;
    else
      nxt_step = step_ff + 4'h1;
  end

  // With a 20 ns clock every cycle is a step; a faster clock only changes the constants
  // one step is 20 ns
  assign tick = (step_ff == STEP_CNT_W'(STEP_CYCLES - 1));

  // Step counter register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      step_ff <= '0;
    else
      step_ff <= nxt_step;
  end

  // One pacer per port and queue; pacer index is port times four plus queue
  // rate is time per byte
  generate
    for (genvar g = 0; g < NUM_PACERS; g++)
    begin : g_pacer
      egress_pacer u_pacer (
        .pclk(pclk),
        .presetn(presetn),
        .rate(rate_ff[g]),
        .enable(pace_en_ff),
        .tick(tick),
        .byte_req(byte_req[g]),
        .byte_grant(byte_grant[g]),
        .busy(queue_busy[g])
      );
    end
  endgenerate

  // Register values the egress datapath uses directly
  assign pace_active = pace_en_ff;
  assign default_vid = vid_ff;
  assign default_pri = pri_ff;

  // Egress tag rewrite for port 0, one cycle of latency
  always_comb
  begin
    nxt_tag_valid = tag_valid_in;
    nxt_tag_vid = tag_vid_ff;
    nxt_tag_pri = tag_pri_ff;
    if (tag_valid_in)
    begin
      nxt_tag_vid = tag_vid_in;
      nxt_tag_pri = tag_pri_in;
      // Priority-tagged frames carry VLAN ID zero, so the default always replaces it
      // priority-tagged always replaced
      if (tag_insert || tag_change_vid || tag_priority_tagged)
        nxt_tag_vid = vid_ff;
      // default priority on insert or change
      if (tag_insert || tag_change_pri)
        nxt_tag_pri = pri_ff;
    end
  end

  // Tag result registers; VLAN ID and priority outputs hold until the next valid, tag_valid_out follows tag_valid_in
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tag_valid_ff <= 1'b0;
      tag_vid_ff <= VID_RESET;
      tag_pri_ff <= PRI_RESET;
    end
    else
    begin
      tag_valid_ff <= nxt_tag_valid;
      tag_vid_ff <= nxt_tag_vid;
      tag_pri_ff <= nxt_tag_pri;
    end
  end

  // Tag outputs straight from flops, so no glitch reaches the frame editor
  assign tag_valid_out = tag_valid_ff;
  assign tag_vid_out = tag_vid_ff;
  assign tag_pri_out = tag_pri_ff;

endmodule
`default_nettype wire

/* File: verification/pacing_tag_regs_properties.sv */
// Checker for the pacing and default tag register bank
`timescale 1ns/1ns
`default_nettype none
module pacing_tag_regs_properties
  import pacing_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic pslverr,
  input wire logic [NUM_PACERS-1:0] byte_req,
  input wire logic [NUM_PACERS-1:0] byte_grant,
  input wire logic [NUM_PACERS-1:0] queue_busy,
  input wire logic pace_active,
  input wire logic tag_valid_in,
  input wire logic tag_priority_tagged,
  input wire logic tag_insert,
  input wire logic tag_change_vid,
  input wire logic [VID_W-1:0] tag_vid_in,
  input wire logic tag_valid_out,
  input wire logic [VID_W-1:0] tag_vid_out,
  input wire logic [PRI_W-1:0] tag_pri_out,
  input wire logic [VID_W-1:0] default_vid,
  input wire logic [PRI_W-1:0] default_pri
);
  // One clock domain, so clock and reset are shared
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_err_odd: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("misaligned access not refused");
  a_err_phase: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  a_grant_off: assert property (!pace_active |-> byte_grant == byte_req)
    else $error("grant differs from request with pacing off");
  a_grant_paced: assert property (pace_active |-> byte_grant == (byte_req & ~queue_busy))
    else $error("grant given while queue busy");
  a_busy_cause: assert property ($rose(queue_busy[1]) |-> $past(byte_grant[1]))
    else $error("queue busy without a byte");
  a_busy_clear: assert property (!pace_active [*3] |-> queue_busy == '0)
    else $error("busy kept with pacing off");
  a_tag_next: assert property (tag_valid_in |=> tag_valid_out)
    else $error("tag result late");
  a_vid_dflt: assert property (tag_valid_in && (tag_insert || tag_change_vid || tag_priority_tagged)
    |=> tag_vid_out == $past(default_vid))
    else $error("default vlan not applied");
  a_vid_pass: assert property (tag_valid_in && !(tag_insert || tag_change_vid || tag_priority_tagged)
    |=> tag_vid_out == $past(tag_vid_in))
    else $error("vlan changed without cause");
  a_pri_ins: assert property (tag_valid_in && tag_insert |=> tag_pri_out == $past(default_pri))
    else $error("default priority not inserted");

  // Main scenarios reached
  c_paced: cover property (pace_active && byte_grant[1]);
  c_err: cover property (pslverr);
  c_tag: cover property (tag_valid_in && tag_insert);
endmodule

bind pacing_tag_regs pacing_tag_regs_properties i_pacing_tag_regs_properties (.pclk, .presetn, .psel,
  .penable, .paddr, .pslverr, .byte_req, .byte_grant, .queue_busy, .pace_active, .tag_valid_in,
  .tag_priority_tagged, .tag_insert, .tag_change_vid, .tag_vid_in, .tag_valid_out, .tag_vid_out,
  .tag_pri_out, .default_vid, .default_pri);
`default_nettype wire

/* File: verification/tb_pacing_tag_regs.sv */
// Self-checking bench for the pacing and default tag register bank
`timescale 1ns/1ns
`default_nettype none
module tb_pacing_tag_regs
  import pacing_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, pace_active;
  logic tag_valid_in, tag_priority_tagged, tag_insert, tag_change_vid, tag_change_pri, tag_valid_out;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic [3:0] pstrb;
  logic [11:0] byte_req, byte_grant, queue_busy, tag_vid_in, tag_vid_out, default_vid;
  logic [2:0] tag_pri_in, tag_pri_out, default_pri;
  logic rd_e;
  int miscompares, compares;

  pacing_tag_regs i_pacing_tag_regs (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .byte_req, .byte_grant, .queue_busy, .pace_active,
    .tag_valid_in, .tag_priority_tagged, .tag_insert, .tag_change_vid, .tag_change_pri, .tag_vid_in,
    .tag_pri_in, .tag_valid_out, .tag_vid_out, .tag_pri_out, .default_vid, .default_pri);

  // 50 MHz clock
  initial
  begin
    forever #10 pclk = ~pclk;
  end

  task automatic stop_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; the wait for pready is bounded so a hang ends the run
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
    begin
      miscompares++;
      stop_test();
    end
    rd_q = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic err);
    apb(1'b0, a, 32'h00000000, 4'h0);
    chk("prdata", rd_q, e);
    chk("pslverr", rd_e, err);
  endtask

  // Hold every request 60 cycles and count grants per queue
  task automatic pace(input logic en);
    int j, n;
    int g [NUM_PACERS];
    for (j = 0; j < NUM_PACERS; j++)
      g[j] = 0;
    byte_req <= 12'hFFF;
    repeat (60)
    begin
      @(posedge pclk);
      for (j = 0; j < NUM_PACERS; j++)
        g[j] += byte_grant[j];
    end
    // Cycle 59 is prime, so only the rate-zero queue is idle in it
    chk("queue_busy", queue_busy, en ? 32'h00000FFE : 32'h00000000);
    byte_req <= 12'h000;
    for (j = 0; j < NUM_PACERS; j++)
    begin
      n = (j % 2) ? j / 2 + 6 : j / 2;
      // one byte per rate plus one steps
      chk("grants", g[j], en ? (60 + n) / (n + 1) : 60);
    end
    @(posedge pclk);
  endtask

  initial
  begin
    int k;
    miscompares = 0;
    compares = 0;
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb, byte_req} = '0;
    {tag_valid_in, tag_priority_tagged, tag_insert, tag_change_vid, tag_change_pri} = '0;
    {tag_vid_in, tag_pri_in} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values of the six rate registers and the tag register
    for (k = 0; k < 7; k++)
      rd(16'h7034 + 16'(4 * k), (k == 6) ? 32'h00000001 : 32'h00000000, 1'b0);
    // distinct rates per queue, reserved bits read zero
    for (k = 0; k < 6; k++)
    begin
      apb(1'b1, 16'h7034 + 16'(4 * k), 32'hFC000000 | 32'((k + 6) << 13) | 32'(k), 4'hF);
      rd(16'h7034 + 16'(4 * k), 32'((k + 6) << 13) | 32'(k), 1'b0);
    end
    apb(1'b1, 16'h704C, 32'hFFFFF5A5, 4'hF);
    rd(16'h704C, 32'h000075A5, 1'b0);
    chk("default_vid", default_vid, 32'h000005A5);
    chk("default_pri", default_pri, 32'h00000007);
    // Low lane only, priority must survive
    apb(1'b1, 16'h704C, 32'h000000FF, 4'h1);
    rd(16'h704C, 32'h000075FF, 1'b0);
    // Unmapped read and misaligned write are refused
    rd(16'h7000, 32'h00000000, 1'b1);
    apb(1'b1, 16'h704E, 32'h00000000, 4'hF);
    chk("pslverr", rd_e, 32'h00000001);
    rd(16'h704C, 32'h000075FF, 1'b0);
    // Pacing on, then off
    for (k = 1; k >= 0; k--)
    begin
      apb(1'b1, 16'h7078, 32'(k), 4'hF);
      chk("pace_active", pace_active, 32'(k));
      pace(k[0]);
      // Status shows the queues still counting out their last byte
      rd(16'h707C, k ? 32'h0000022A : 32'h00000000, 1'b0);
      rd(16'h7078, 32'(k), 1'b0);
    end
    // Status is read-only: a write is dropped without an error
    apb(1'b1, 16'h707C, 32'hFFFFFFFF, 4'hF);
    chk("pslverr", rd_e, 32'h00000000);
    rd(16'h707C, 32'h00000000, 1'b0);
    // every flag combination against the defaults
    for (k = 0; k < 16; k++)
    begin
      tag_valid_in <= 1'b1;
      {tag_insert, tag_change_vid, tag_change_pri, tag_priority_tagged} <= 4'(k);
      tag_vid_in <= 12'hABC;
      tag_pri_in <= 3'h2;
      @(posedge pclk);
      tag_valid_in <= 1'b0;
      @(posedge pclk);
      chk("tag_valid_out", tag_valid_out, 32'h00000001);
      chk("tag_vid_out", tag_vid_out, (k & 13) ? 32'h000005FF : 32'h00000ABC);
      chk("tag_pri_out", tag_pri_out, (k & 10) ? 32'h00000007 : 32'h00000002);
    end
    stop_test();
  end
endmodule
`default_nettype wire
